// *** src/timer16_wave_pkg.sv ***
// Constants and types for the 16-bit timer waveform mode and compare output block
package timer16_wave_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_A_OFS   = 8'h80;
  localparam logic [7:0] CTRL_B_OFS   = 8'h84;
  localparam logic [7:0] CMP_A_OFS    = 8'h88;
  localparam logic [7:0] CMP_B_OFS    = 8'h8c;
  localparam logic [7:0] CAPT_OFS     = 8'h90;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h94;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h98;
  localparam logic [7:0] LIVE_OFS     = 8'h9c;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ACT_A_POS   = 6;
  localparam int ACT_B_POS   = 4;
  localparam int MODE_LO_POS = 0;
  localparam int MODE_HI_POS = 3;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_CMA_BIT = 1;
  localparam int IRQ_CMB_BIT = 2;
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] CMP_RST  = 16'h0000;
  localparam logic [2:0]  IRQ_RST  = 3'h0;
  // ----------------------------------------------------------------
  // Fixed top values and output-action encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] TOP_BITS8  = 16'h00ff;
  localparam logic [15:0] TOP_BITS9  = 16'h01ff;
  localparam logic [15:0] TOP_BITS10 = 16'h03ff;
  localparam logic [15:0] TOP_MAX    = 16'hffff;
  localparam logic [15:0] BOTTOM_VAL = 16'h0000;
  localparam logic [1:0]  ACT_OFF    = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE = 2'h1;
  localparam logic [1:0]  ACT_CLEAR  = 2'h2;
  localparam logic [1:0]  ACT_SET    = 2'h3;
  // ----------------------------------------------------------------
  // Decoded mode types
  // ----------------------------------------------------------------
  typedef enum {FAM_NORMAL, FAM_CTC, FAM_FAST, FAM_PHASE, FAM_PFC, FAM_RESERVED} wave_family_t;
  typedef enum {TOP_FIXED, TOP_CMPA, TOP_CAPT} top_src_t;
  typedef enum {UPD_NOW, UPD_TOP, UPD_BOTTOM} update_pt_t;
  typedef enum {OVF_MAX, OVF_TOP, OVF_BOTTOM} ovf_pt_t;
endpackage : timer16_wave_pkg

// *** src/mode_if.sv ***
// Decoded waveform mode shared between decoder and compare channels
`timescale 1ns/1ps
interface mode_if;
  import timer16_wave_pkg::*;
  wave_family_t family;
  top_src_t     topSrc;
  logic [15:0]  fixedTop;
  update_pt_t   updatePt;
  ovf_pt_t      ovfPt;
  logic         toggleAOk;
  modport dec (output family, topSrc, fixedTop, updatePt, ovfPt, toggleAOk);
  modport chan (input family, topSrc, fixedTop, updatePt, ovfPt, toggleAOk);
endinterface : mode_if

// *** src/mode_decode.sv ***
// Four-bit waveform mode decoder
`timescale 1ns/1ps
module mode_decode
  import timer16_wave_pkg::*;
(
  // Mode field
  input  logic [3:0] waveMode,
  // Decoded mode
  mode_if.dec        modeBus
);
  always_comb begin
    modeBus.family    = FAM_NORMAL;
    modeBus.topSrc    = TOP_FIXED;
    modeBus.fixedTop  = TOP_MAX;
    modeBus.updatePt  = UPD_NOW;
    modeBus.ovfPt     = OVF_MAX;
    modeBus.toggleAOk = 1'b0;
    unique case (waveMode)
      4'h0: begin end
      4'h1, 4'h2, 4'h3: begin
        modeBus.family   = FAM_PHASE;
        modeBus.fixedTop = (waveMode == 4'h1) ? TOP_BITS8 : (waveMode == 4'h2) ? TOP_BITS9 : TOP_BITS10;
        modeBus.updatePt = UPD_TOP;
        modeBus.ovfPt    = OVF_BOTTOM;
      end
      4'h4, 4'hc: begin
        modeBus.family = FAM_CTC;
        modeBus.topSrc = (waveMode == 4'h4) ? TOP_CMPA : TOP_CAPT;
      end
      4'h5, 4'h6, 4'h7: begin
        modeBus.family   = FAM_FAST;
        modeBus.fixedTop = (waveMode == 4'h5) ? TOP_BITS8 : (waveMode == 4'h6) ? TOP_BITS9 : TOP_BITS10;
        modeBus.updatePt = UPD_BOTTOM;
        modeBus.ovfPt    = OVF_TOP;
      end
      4'h8, 4'h9: begin
        modeBus.family    = FAM_PFC;
        modeBus.topSrc    = (waveMode == 4'h8) ? TOP_CAPT : TOP_CMPA;
        modeBus.updatePt  = UPD_BOTTOM;
        modeBus.ovfPt     = OVF_BOTTOM;
        modeBus.toggleAOk = (waveMode == 4'h9);
      end
      4'ha, 4'hb: begin
        modeBus.family    = FAM_PHASE;
        modeBus.topSrc    = (waveMode == 4'ha) ? TOP_CAPT : TOP_CMPA;
        modeBus.updatePt  = UPD_TOP;
        modeBus.ovfPt     = OVF_BOTTOM;
        modeBus.toggleAOk = (waveMode == 4'hb);
      end
      4'hd: modeBus.family = FAM_RESERVED;
      4'he, 4'hf: begin
        modeBus.family    = FAM_FAST;
        modeBus.topSrc    = (waveMode == 4'he) ? TOP_CAPT : TOP_CMPA;
        modeBus.updatePt  = UPD_BOTTOM;
        modeBus.ovfPt     = OVF_TOP;
        modeBus.toggleAOk = 1'b1;
      end
    endcase
  end
endmodule : mode_decode

// *** src/compare_channel.sv ***
// One compare output channel: pin ownership and output action
`timescale 1ns/1ps
module compare_channel
  import timer16_wave_pkg::*;
#(
  parameter bit IS_A = 1'b0
) (
  // Clock, reset, enable
  input  logic       clk,
  input  logic       nrst,
  input  logic       en,
  // Setup
  input  logic [1:0] action,
  mode_if.chan       modeBus,
  // Counter events
  input  logic       tick,
  input  logic       match,
  input  logic       atBottom,
  input  logic       cmpEqTop,
  input  logic       countDown,
  // Result
  output logic       ocOut_q,
  output logic       connected
);
  logic pwmFam;
  logic toggleOk;

  assign pwmFam   = modeBus.family inside {FAM_FAST, FAM_PHASE, FAM_PFC};
  assign toggleOk = !pwmFam || (IS_A && modeBus.toggleAOk);

  // Toggle encoding in PWM modes is only honoured on channel A of certain modes
  always_comb begin
    connected = (action != ACT_OFF) && (modeBus.family != FAM_RESERVED);
    if (action == ACT_TOGGLE && !toggleOk)
      connected = 1'b0;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ocOut_q <= 1'b0;
    end else if (en && tick && connected) begin
      unique case (modeBus.family)
        FAM_NORMAL, FAM_CTC, FAM_RESERVED: begin
          if (match) begin
            unique case (action)
              ACT_TOGGLE: ocOut_q <= !ocOut_q;
              ACT_CLEAR:  ocOut_q <= 1'b0;
              ACT_SET:    ocOut_q <= 1'b1;
              ACT_OFF:    ocOut_q <= ocOut_q;
            endcase
          end
        end
        FAM_FAST: begin
          if (action == ACT_TOGGLE) begin
            if (match) ocOut_q <= !ocOut_q;
          end else if (match && !cmpEqTop) begin
            ocOut_q <= action[0];
          end else if (atBottom) begin
            ocOut_q <= !action[0];
          end
        end
        FAM_PHASE, FAM_PFC: begin
          if (match) begin
            if (action == ACT_TOGGLE) ocOut_q <= !ocOut_q;
            else ocOut_q <= countDown ? !action[0] : action[0];
          end
        end
      endcase
    end
  end
endmodule : compare_channel

// *** src/timer16_wave_ctrl.sv ***
// Timer waveform mode control: registers, compare buffering, compare pins
`timescale 1ns/1ps
// What this block does
// - A nonzero output-action field hands the pin to the compare output except in reserved mode 13 and for a refused PWM toggle, zero leaves the port in charge.
// - The pin driver is enabled only by the pin direction bit, whoever owns the pin.
// - In normal and clear-on-match modes 01 toggles, 10 clears and 11 sets on match, 00 disconnects.
// - In fast PWM, 01 toggles output A only in modes 14 and 15, and otherwise both outputs disconnect.
// - In fast PWM, 10 clears on match and sets at bottom, 11 sets on match and clears at bottom.
// - In fast PWM a match at a compare value equal to top is ignored when the upper action bit is set.
// - In dual-slope PWM, 01 toggles output A only in modes 9 and 11, and otherwise both outputs disconnect.
// - In dual-slope PWM, 10 clears on an up-count match and sets on a down-count match, 11 the reverse.
// - The two low mode bits sit in bits 1 to 0 and combine with the high bits to pick the mode.
// - Modes 1 to 3 are phase-correct with fixed tops 0x00ff, 0x01ff, 0x03ff, update at top, overflow at bottom.
// - Modes 8 and 9 are phase-and-frequency-correct with capture or compare A top, update and overflow at bottom.
// - The mode field offers plain counting, clear on match and three PWM families.
// - The two high mode bits sit in bits 4 to 3 of the second control register.
module timer16_wave_ctrl
  import timer16_wave_pkg::*;
(
  // Clock, reset, enable
  input  logic        clk,
  input  logic        nrst,
  input  logic        en,
  // Wishbone slave
  input  logic        cyc_i,
  input  logic        stb_i,
  input  logic        we_i,
  input  logic [7:0]  adr_i,
  input  logic [3:0]  sel_i,
  input  logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic        ack_o,
  // Counter core
  input  logic [15:0] cntValue,
  input  logic        cntTick,
  input  logic        cntDown,
  output logic [15:0] topValue,
  // Port pins
  input  logic        portDataA,
  input  logic        portDirA,
  input  logic        portDataB,
  input  logic        portDirB,
  output logic        pinOutA,
  output logic        pinOeA,
  output logic        pinOutB,
  output logic        pinOeB,
  // Interrupt
  output logic        irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrlA_q;
  logic [1:0]  modeHi_q;
  logic [15:0] cmpBufA_q;
  logic [15:0] cmpBufB_q;
  logic [15:0] cmpA_q;
  logic [15:0] cmpB_q;
  logic [15:0] capt_q;
  logic [15:0] top_q;
  logic [2:0]  stat_q;
  logic [2:0]  mask_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        irq_q;
  logic        pinOutA_q;
  logic        pinOeA_q;
  logic        pinOutB_q;
  logic        pinOeB_q;
  logic [31:0] rdData;
  logic [3:0]  waveMode;
  logic [1:0]  actA;
  logic [1:0]  actB;
  logic        req;
  logic        wrStrobe;
  logic        atTop;
  logic        atBottom;
  logic        atMax;
  logic        matchA;
  logic        matchB;
  logic        ovfEvent;
  logic        updNow;
  logic        ocA;
  logic        ocB;
  logic        ownA;
  logic        ownB;
  logic [15:0] topNext;
  logic [15:0] wrWord;

  mode_if modeBus ();

  assign actA     = ctrlA_q[ACT_A_POS+:2];
  assign actB     = ctrlA_q[ACT_B_POS+:2];
  assign waveMode = {modeHi_q, ctrlA_q[MODE_LO_POS+:2]};
  assign dat_o    = dat_q;
  assign ack_o    = ack_q;
  assign irq      = irq_q;
  assign topValue = top_q;
  assign pinOutA  = pinOutA_q;
  assign pinOeA   = pinOeA_q;
  assign pinOutB  = pinOutB_q;
  assign pinOeB   = pinOeB_q;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  mode_decode u_dec (
    .waveMode (waveMode),
    .modeBus  (modeBus.dec)
  );

  compare_channel #(.IS_A(1'b1)) u_chA (
    .clk       (clk),
    .nrst      (nrst),
    .en        (en),
    .action    (actA),
    .modeBus   (modeBus.chan),
    .tick      (cntTick),
    .match     (matchA),
    .atBottom  (atBottom),
    .cmpEqTop  (cmpA_q == top_q),
    .countDown (cntDown),
    .ocOut_q   (ocA),
    .connected (ownA)
  );

  compare_channel #(.IS_A(1'b0)) u_chB (
    .clk       (clk),
    .nrst      (nrst),
    .en        (en),
    .action    (actB),
    .modeBus   (modeBus.chan),
    .tick      (cntTick),
    .match     (matchB),
    .atBottom  (atBottom),
    .cmpEqTop  (cmpB_q == top_q),
    .countDown (cntDown),
    .ocOut_q   (ocB),
    .connected (ownB)
  );

  // ----------------------------------------------------------------
  // Wishbone slave: ack one cycle after the request, write at ack
  // ----------------------------------------------------------------
  assign req      = cyc_i && stb_i;
  assign wrStrobe = req && we_i && ack_q;
  // Byte lanes 0 and 1 carry the 16-bit values
  assign wrWord   = {sel_i[1] ? dat_i[15:8] : 8'h00, sel_i[0] ? dat_i[7:0] : 8'h00};

  always_comb begin
    unique case (adr_i)
      CTRL_A_OFS:   rdData = {24'h000000, ctrlA_q[7:4], 2'h0, ctrlA_q[1:0]};
      CTRL_B_OFS:   rdData = {27'h0000000, modeHi_q, 3'h0};
      CMP_A_OFS:    rdData = {16'h0000, cmpBufA_q};
      CMP_B_OFS:    rdData = {16'h0000, cmpBufB_q};
      CAPT_OFS:     rdData = {16'h0000, capt_q};
      IRQ_STAT_OFS: rdData = {29'h00000000, stat_q};
      IRQ_MASK_OFS: rdData = {29'h00000000, mask_q};
      LIVE_OFS:     rdData = {12'h000, ownB, ownA, ocB, ocA, top_q};
      default:      rdData = 32'h00000000;
    endcase
  end

  // Read data is caught at the request edge so it stands through ack
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else if (en) begin
      ack_q <= req && !ack_q;
      if (req && !ack_q)
        dat_q <= rdData;
    end
  end

  // ----------------------------------------------------------------
  // Control and compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrlA_q  <= CTRL_RST;
      modeHi_q <= 2'h0;
    end else if (en && wrStrobe && sel_i[0]) begin
      if (adr_i == CTRL_A_OFS)
        ctrlA_q <= {dat_i[7:4], 2'h0, dat_i[1:0]};
      if (adr_i == CTRL_B_OFS)
        modeHi_q <= dat_i[MODE_HI_POS+:2];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmpBufA_q <= CMP_RST;
      cmpBufB_q <= CMP_RST;
      capt_q    <= CMP_RST;
    end else if (en && wrStrobe) begin
      if (adr_i == CMP_A_OFS) cmpBufA_q <= wrWord;
      if (adr_i == CMP_B_OFS) cmpBufB_q <= wrWord;
      if (adr_i == CAPT_OFS)  capt_q    <= wrWord;
    end
  end

  // ----------------------------------------------------------------
  // Top, match and double-buffer update
  // ----------------------------------------------------------------
  assign atTop    = cntValue == top_q;
  assign atBottom = cntValue == BOTTOM_VAL;
  assign atMax    = cntValue == TOP_MAX;
  assign matchA   = cntValue == cmpA_q;
  assign matchB   = cntValue == cmpB_q;

  always_comb begin
    unique case (modeBus.updatePt)
      UPD_NOW:    updNow = 1'b1;
      UPD_TOP:    updNow = cntTick && atTop;
      UPD_BOTTOM: updNow = cntTick && atBottom;
    endcase
    unique case (modeBus.ovfPt)
      OVF_MAX:    ovfEvent = cntTick && atMax;
      OVF_TOP:    ovfEvent = cntTick && atTop;
      OVF_BOTTOM: ovfEvent = cntTick && atBottom;
    endcase
    unique case (modeBus.topSrc)
      TOP_FIXED: topNext = modeBus.fixedTop;
      TOP_CMPA:  topNext = cmpA_q;
      TOP_CAPT:  topNext = capt_q;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmpA_q <= CMP_RST;
      cmpB_q <= CMP_RST;
    end else if (en && updNow) begin
      cmpA_q <= cmpBufA_q;
      cmpB_q <= cmpBufB_q;
    end
  end

  // Registered so the counter sees a clean top; one cycle behind a mode change
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) top_q <= TOP_MAX;
    else if (en) top_q <= topNext;
  end

  // ----------------------------------------------------------------
  // Interrupt status: hardware set wins over write-one-to-clear
  // ----------------------------------------------------------------
  logic [2:0] statSet;
  logic [2:0] statClr;
  // Match flags rise in PWM modes too, so software can pace updates
  assign statSet = {cntTick && matchB, cntTick && matchA, ovfEvent};
  assign statClr = (wrStrobe && sel_i[0] && adr_i == IRQ_STAT_OFS) ? dat_i[2:0] : 3'h0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= IRQ_RST;
      mask_q <= IRQ_RST;
      irq_q  <= 1'b0;
    end else if (en) begin
      stat_q <= (stat_q & ~statClr) | statSet;
      if (wrStrobe && sel_i[0] && adr_i == IRQ_MASK_OFS)
        mask_q <= dat_i[2:0];
      irq_q <= |(stat_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Compare pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinOutA_q <= 1'b0;
      pinOeA_q  <= 1'b0;
      pinOutB_q <= 1'b0;
      pinOeB_q  <= 1'b0;
    end else if (en) begin
      pinOutA_q <= ownA ? ocA : portDataA;
      pinOutB_q <= ownB ? ocB : portDataB;
      pinOeA_q  <= portDirA;
      pinOeB_q  <= portDirB;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Pins and flags are registered, so checks look one edge back
  logic fastFam;
  logic dualFam;
  assign fastFam = modeBus.family == FAM_FAST;
  assign dualFam = modeBus.family inside {FAM_PHASE, FAM_PFC};

  pin_owner_a: assert property (en && ownA |=> pinOutA_q == $past(ocA))
    else $error("compare output A not on pin");
  port_keep_a: assert property (en && actB == ACT_OFF |=> pinOutB_q == $past(portDataB))
    else $error("port data B not kept");
  driver_dir_a: assert property (en |=> pinOeA_q == $past(portDirA) && pinOeB_q == $past(portDirB))
    else $error("driver enable not following direction");
  nonpwm_set_a: assert property (en && cntTick && matchA && modeBus.family inside {FAM_NORMAL, FAM_CTC}
                                 && actA == ACT_SET |=> ocA)
    else $error("set on match missing");
  fast_tog_b_a: assert property (fastFam && actB == ACT_TOGGLE |-> !ownB)
    else $error("fast toggle reached output B");
  fast_bottom_a: assert property (en && cntTick && atBottom && !matchA && fastFam && actA == ACT_CLEAR |=> ocA)
    else $error("bottom set missing");
  top_ignore_a: assert property (en && cntTick && matchA && !atBottom && cmpA_q == top_q && fastFam
                                 && actA[1] |=> ocA == $past(ocA))
    else $error("match at top not ignored");
  dual_tog_a: assert property (dualFam && actA == ACT_TOGGLE && !(waveMode inside {4'h9, 4'hb}) |-> !ownA)
    else $error("dual slope toggle not disconnected");
  dual_down_a: assert property (en && cntTick && matchA && cntDown && dualFam && actA == ACT_CLEAR |=> ocA)
    else $error("down count match did not set");
  phase_top_a: assert property (en && waveMode == 4'h2 ##1 en && waveMode == 4'h2 |-> top_q == TOP_BITS9)
    else $error("fixed 9-bit top wrong");
  pfc_update_a: assert property (en && waveMode == 4'h9 && cntTick && atBottom |=> cmpA_q == $past(cmpBufA_q))
    else $error("bottom update missing");
  mode_join_a: assert property (waveMode == {modeHi_q, ctrlA_q[1:0]} && modeHi_q == $past(modeHi_q)
                                || $past(wrStrobe))
    else $error("high mode bits changed without a write");
  norm_ovf_a: assert property (en && waveMode == 4'h0 && cntTick && atMax |=> stat_q[IRQ_OVF_BIT])
    else $error("overflow at max missing");
  fast_ovf_a: assert property (en && fastFam && cntTick && atTop |=> stat_q[IRQ_OVF_BIT])
    else $error("overflow at top missing");
  ack_pulse_a: assert property (en && ack_q |=> !ack_q)
    else $error("ack held two cycles");
  dual_up_a: assert property (en && cntTick && matchA && !cntDown && dualFam && actA == ACT_CLEAR |=> !ocA)
    else $error("up count match did not clear");
  fast_update_a: assert property (en && fastFam && cntTick && atBottom |=> cmpB_q == $past(cmpBufB_q))
    else $error("fast bottom update missing");
  reserved_off_a: assert property (modeBus.family == FAM_RESERVED |-> !ownA && !ownB)
    else $error("reserved mode drives a pin");
  irq_level_a: assert property (en |=> irq_q == |($past(stat_q) & $past(mask_q)))
    else $error("interrupt level wrong");

  fast_cycle_c: cover property (fastFam && actA == ACT_CLEAR && cntTick && matchA ##[1:300] cntTick && atBottom);
  dual_down_c: cover property (dualFam && cntTick && cntDown && matchA);
  irq_fire_c: cover property (!irq_q ##1 irq_q);
  toggle_a_c: cover property (modeBus.toggleAOk && actA == ACT_TOGGLE && cntTick && matchA);
  pfc_update_c: cover property (waveMode == 4'h9 && cntTick && atBottom);
endmodule : timer16_wave_ctrl

// *** tb/port_model.sv ***
// Port pad model: direction and data latches with a pull-up on the pad
`timescale 1ns/1ps
module port_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Software side
  input  wire logic setDir,
  input  wire logic setData,
  // Towards the timer block
  output logic      portDir,
  output logic      portData,
  // Timer pin and resolved pad
  input  wire logic pinOut,
  input  wire logic pinOe,
  output logic      pad
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      portDir  <= 1'b0;
      portData <= 1'b0;
    end else begin
      portDir  <= setDir;
      portData <= setData;
    end
  end
  // Undriven pad settles at the pull-up level
  assign pad = pinOe ? pinOut : 1'b1;
endmodule : port_model

// *** tb/testbench.sv ***
// Self-checking testbench for the timer waveform mode control block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin mismatches++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end
module testbench;
  import timer16_wave_pkg::*;
  logic        clk, nrst, en, cyc, stb, we, ack, tick, down, irq;
  logic        dirA, dirB, datA, datB, pDirA, pDirB, pDatA, pDatB, outA, outB, oeA, oeB, padA, padB;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, r;
  logic [15:0] cnt, top, ca, cp;
  int          mismatches, comparisons, m, act;

  timer16_wave_ctrl i_timer16_wave_ctrl (.clk(clk), .nrst(nrst), .en(en), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .cntValue(cnt),
    .cntTick(tick), .cntDown(down), .topValue(top), .portDataA(pDatA), .portDirA(pDirA),
    .portDataB(pDatB), .portDirB(pDirB), .pinOutA(outA), .pinOeA(oeA), .pinOutB(outB),
    .pinOeB(oeB), .irq(irq));
  port_model i_port_model_a (.clk(clk), .nrst(nrst), .setDir(dirA), .setData(datA),
    .portDir(pDirA), .portData(pDatA), .pinOut(outA), .pinOe(oeA), .pad(padA));
  port_model i_port_model_b (.clk(clk), .nrst(nrst), .setDir(dirB), .setData(datB),
    .portDir(pDirB), .portData(pDatB), .pinOut(outB), .pinOe(oeB), .pad(padB));

  // ----------------------------------------------------------------
  // Bus, counter and expectation helpers
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= 4'h3;
    adr  <= a;
    wdat <= d;
    do @(posedge clk);
    while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic setMode(input logic [3:0] md, input logic [1:0] aa, input logic [1:0] ab);
    wb(1'b1, CTRL_A_OFS, {24'h0, aa, ab, 2'h0, md[1:0]});
    wb(1'b1, CTRL_B_OFS, {27'h0, md[3:2], 3'h0});
    repeat (2) @(posedge clk);
  endtask : setMode

  // One timer tick at the given count; the pins settle two edges later
  task automatic ev(input logic [15:0] v, input logic d);
    @(posedge clk);
    cnt  <= v;
    down <= d;
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    cnt  <= 16'h0010;
    repeat (4) @(posedge clk);
  endtask : ev

  function automatic logic own(input logic [3:0] md, input logic [1:0] ac, input logic isA);
    if (ac == 2'h0) return 1'b0;
    if (ac != 2'h1) return md != 4'hd;
    return md inside {4'h0, 4'h4, 4'hc} || (isA && md inside {4'h9, 4'hb, 4'he, 4'hf});
  endfunction : own

  function automatic logic [15:0] topOf(input logic [3:0] md);
    case (md)
      4'h1, 4'h5: return 16'h00ff;
      4'h2, 4'h6: return 16'h01ff;
      4'h3, 4'h7: return 16'h03ff;
      4'h4, 4'h9, 4'hb, 4'hf: return ca;
      4'h8, 4'ha, 4'hc, 4'he: return cp;
      default: return 16'hffff;
    endcase
  endfunction : topOf

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #80000;
    mismatches++;
    end_of_test();
  end

  initial begin
    r = $urandom(44691);
    {nrst, cyc, stb, we, tick, down, dirA, dirB, datA, datB} = '0;
    {en, adr, sel, wdat, cnt, mismatches, comparisons} = '0;
    en = 1'b1;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 8'h80; a <= 8'h98; a += 4) begin
      wb(1'b0, a[7:0], 32'h0);
      `CHK("reset value", 32'h0, r)
    end
    wb(1'b1, CTRL_A_OFS, 32'hff);
    wb(1'b0, CTRL_A_OFS, 32'h0);
    `CHK("ctrl a fields", 32'hf3, r)
    wb(1'b1, CTRL_B_OFS, 32'hff);
    wb(1'b0, CTRL_B_OFS, 32'h0);
    `CHK("ctrl b fields", 32'h18, r)
    wb(1'b1, 8'ha0, 32'hff);
    wb(1'b0, 8'ha0, 32'h0);
    `CHK("unmapped", 32'h0, r)
    for (m = 0; m < 16; m++) begin
      if (m == 13) continue;
      ca = 16'h10 + 16'($urandom % 100);
      cp = 16'($urandom);
      setMode(4'h0, 2'h0, 2'h0);
      wb(1'b1, CMP_A_OFS, {16'h0, ca});
      wb(1'b1, CAPT_OFS, {16'h0, cp});
      setMode(m[3:0], 2'h0, 2'h0);
      `CHK("top value", topOf(m[3:0]), top)
    end
    for (int i = 0; i < 24; i++) begin
      m = i < 16 ? i : $urandom % 16;
      act = i < 16 ? 1 : $urandom % 4;
      setMode(m[3:0], act[1:0], act[1:0]);
      wb(1'b0, LIVE_OFS, 32'h0);
      `CHK("own a", own(m[3:0], act[1:0], 1'b1), r[18])
      `CHK("own b", own(m[3:0], act[1:0], 1'b0), r[19])
    end
    setMode(4'h0, 2'h0, 2'h0);
    wb(1'b1, CMP_A_OFS, {16'h0, ca});
    wb(1'b1, CMP_B_OFS, {16'h0, ca});
    dirA <= 1'b1;
    dirB <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      act = (i == 0) ? 3 : (i == 1) ? 2 : 1;
      datA <= i[0];
      datB <= i[0];
      setMode(4'h0, act[1:0], act[1:0]);
      ev(ca, 1'b0);
      `CHK("match a", ~i[0], outA)
      `CHK("match b", ~i[0], outB)
    end
    setMode(4'h0, 2'h0, 2'h0);
    `CHK("port data a", 1'b1, outA)
    dirA <= 1'b0;
    setMode(4'h0, 2'h3, 2'h3);
    `CHK("oe a", 1'b0, oeA)
    `CHK("pad a", 1'b1, padA)
    `CHK("oe b", 1'b1, oeB)
    dirA <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      datA <= 1'b1;
      datB <= 1'b0;
      setMode(p ? 4'h1 : 4'h5, 2'h2, 2'h3);
      ev(ca, 1'b0);
      `CHK("first a", 1'b0, outA)
      `CHK("first b", 1'b1, outB)
      datA <= 1'b0;
      datB <= 1'b1;
      ev(p ? ca : 16'h0, p[0]);
      `CHK("second a", 1'b1, outA)
      `CHK("second b", 1'b0, outB)
    end
    datA <= 1'b1;
    setMode(4'hf, 2'h1, 2'h1);
    ev(ca, 1'b0);
    `CHK("toggle a", 1'b0, outA)
    `CHK("port b", 1'b1, outB)
    setMode(4'hf, 2'h3, 2'h0);
    ev(ca, 1'b0);
    `CHK("top match", 1'b0, outA)
    datA <= 1'b0;
    setMode(4'hb, 2'h1, 2'h1);
    ev(ca, 1'b0);
    `CHK("dual toggle a", 1'b1, outA)
    setMode(4'h9, 2'h0, 2'h0);
    wb(1'b1, CMP_A_OFS, {16'h0, ca + 16'h1});
    wb(1'b1, CMP_B_OFS, {16'h0, ca + 16'h1});
    `CHK("pfc held", ca, top)
    ca = ca + 16'h1;
    ev(16'h0, 1'b0);
    `CHK("pfc update", ca, top)
    setMode(4'h0, 2'h0, 2'h0);
    wb(1'b1, IRQ_STAT_OFS, 32'h7);
    ev(ca, 1'b0);
    ev(16'hffff, 1'b0);
    wb(1'b0, IRQ_STAT_OFS, 32'h0);
    `CHK("status", 32'h7, r)
    `CHK("masked irq", 1'b0, irq)
    wb(1'b1, IRQ_MASK_OFS, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    wb(1'b1, IRQ_STAT_OFS, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    wb(1'b0, IRQ_STAT_OFS, 32'h0);
    `CHK("status left", 32'h6, r)
    end_of_test();
  end
endmodule : testbench
